// >>> verilog/cmcs_pkg.sv
// Constants and types shared by the control mode configuration select block
package cmcs_pkg;

	// Clock of this block (readout domain)
	localparam int CMCS_CLK_NS = 50;

	// Serial frame layout: 12-bit header, 4-bit address, 16 data bits
	localparam int             CMCS_FRAME_BITS = 32;
	localparam logic [4:0]     CMCS_FRAME_LAST = 5'h1f;
	localparam logic [11:0]    CMCS_FRAME_HDR  = 12'h001;
	localparam int             CMCS_ADDR_W     = 4;
	localparam int             CMCS_DATA_W     = 16;

	// Register addresses
	localparam logic [3:0] CMCS_ADDR_CONFIG   = 4'h1;
	localparam logic [3:0] CMCS_ADDR_OFFSET   = 4'h2;
	localparam logic [3:0] CMCS_ADDR_FULLSCL  = 4'h3;
	localparam logic [3:0] CMCS_ADDR_PH_FINE  = 4'hd;
	localparam logic [3:0] CMCS_ADDR_PH_CRS   = 4'he;
	localparam logic [3:0] CMCS_ADDR_BUF_PAT  = 4'hf;

	// Configuration register fields
	localparam int CMCS_CFG_DIFF_RST_BIT  = 14;
	localparam int CMCS_CFG_TRIM_DIS_BIT  = 13;
	localparam int CMCS_CFG_DUTY_STAB_BIT = 12;
	localparam int CMCS_CFG_DDR_PH_BIT    = 11;
	localparam int CMCS_CFG_SINGLE_BIT    = 10;
	localparam int CMCS_CFG_EDGE_BIT      = 8;
	// Adjust fields of offset and full-scale registers
	localparam int CMCS_ADJ_LSB           = 7;
	localparam int CMCS_ADJ_MSB           = 15;
	// Pattern output select in buffer/pattern register
	localparam int CMCS_PAT_SEL_BIT       = 11;

	// Power-on values of the registers
	localparam logic [15:0] CMCS_CONFIG_RST   = 16'h9eff;
	localparam logic [15:0] CMCS_OFFSET_RST   = 16'h0000;
	localparam logic [15:0] CMCS_FULLSCL_RST  = 16'h8000;
	localparam logic [15:0] CMCS_PH_FINE_RST  = 16'h0000;
	localparam logic [15:0] CMCS_PH_CRS_RST   = 16'h0000;
	localparam logic [15:0] CMCS_BUF_PAT_RST  = 16'h0000;

	// Three-level pin codes from the pin level detector
	localparam logic [1:0] CMCS_PIN_LOW  = 2'h0;
	localparam logic [1:0] CMCS_PIN_MID  = 2'h1;
	localparam logic [1:0] CMCS_PIN_HIGH = 2'h3;

	// Settle time before the control mode is captured
	localparam int CMCS_MODE_SETTLE_NS  = 150;
	localparam int CMCS_MODE_SETTLE_CYC =
		(CMCS_MODE_SETTLE_NS + CMCS_CLK_NS - 1) / CMCS_CLK_NS;

	typedef enum logic {
		CMCS_MODE_WAIT,
		CMCS_MODE_HELD
	} cmcs_mode_st_t;

endpackage

// >>> verilog/cmcs_serial_rx.sv
// Serial configuration frame receiver for the register bank
`timescale 1ns/100ps
`default_nettype none
module cmcs_serial_rx
	import cmcs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        serial_sel_n,
	output logic             frame_valid,
	output logic [3:0]       frame_addr,
	output logic [15:0]      frame_data
);

	logic [2:0]  sclk_sync_r;
	logic [1:0]  sdat_sync_r;
	logic [1:0]  ssel_sync_r;
	logic [30:0] shift_r;
	logic [4:0]  bit_cnt_r;
	logic        sclk_rise;

	// Pins are asynchronous; two stages before any use, third for edges
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_sync_r <= 3'h0;
			sdat_sync_r <= 2'h0;
			ssel_sync_r <= 2'h3;
		end else begin
			sclk_sync_r <= {sclk_sync_r[1:0], serial_clk};
			sdat_sync_r <= {sdat_sync_r[0], serial_data};
			ssel_sync_r <= {ssel_sync_r[0], serial_sel_n};
		end
	end

	assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];

	// Shift MSB first on rising serial clock; 33rd edge starts a new frame
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shift_r   <= 31'h0;
			bit_cnt_r <= 5'h0;
		end else if (ssel_sync_r[1]) begin
			bit_cnt_r <= 5'h0; // Deselect aborts a partial frame
		end else if (sclk_rise) begin
			shift_r   <= {shift_r[29:0], sdat_sync_r[1]};
			bit_cnt_r <= (bit_cnt_r == CMCS_FRAME_LAST) ? 5'h0 :
				bit_cnt_r + 5'h1;
		end
	end

	// Frame is delivered only when the header matches exactly
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			frame_valid <= 1'h0;
			frame_addr  <= 4'h0;
			frame_data  <= 16'h0;
		end else begin
			frame_valid <= sclk_rise && !ssel_sync_r[1] &&
				bit_cnt_r == CMCS_FRAME_LAST &&
				shift_r[30:19] == CMCS_FRAME_HDR;
			frame_addr  <= shift_r[18:15];
			frame_data  <= {shift_r[14:0], sdat_sync_r[1]};
		end
	end

endmodule // cmcs_serial_rx
`default_nettype wire

// >>> verilog/cmcs_top.sv
// Control mode select, configuration registers and output strobe logic
// Operation
// - Extended mode ignores rate, range and delay pins
// - Configuration bit 10 clear selects double rate
// - Single rate: strobe frequency equals word rate
// - Double rate: strobe half rate, both edges
// - Normal mode: mid-level rate pin means double
// - Normal single rate: pin level picks edge
// - Extended mode: configuration bit 8 picks edge
// - Strobe phase zero normally, bit 11 extended
// - Power-down pin high powers core down
// - Output path stays alive during power-down
// - Outputs timed by the readout clock
// - Extended offset from register 2h bits 15:7
// - Pattern select bit puts pattern on outputs
// - Clock phase registers act only when extended
// - Delay pin normally; short delay when extended
// - Extended power-on defaults for configuration bits
// - Extended power-on defaults for trim registers
// - Two converters, one per clock edge
// - Writes are 32-bit header-address-data frames
// - Registers have no effect in normal mode
`timescale 1ns/100ps
`default_nettype none
module cmcs_top
	import cmcs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [1:0]  range_or_mode_pin,
	input  wire logic [1:0]  edge_or_rate_pin,
	input  wire logic        cal_delay_pin,
	input  wire logic        power_down_pin,
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        serial_sel_n,
	input  wire logic [7:0]  buf_word_a,
	input  wire logic [7:0]  buf_word_b,
	input  wire logic        buf_word_valid,
	input  wire logic        buffer_empty_in,
	input  wire logic        capture_full_in,
	input  wire logic        out_of_range_in,
	output logic             buf_word_ready,
	output logic [7:0]       data_a,
	output logic [7:0]       data_b,
	output logic             output_strobe,
	output logic             buffer_empty_flag,
	output logic             capture_full_flag,
	output logic             out_of_range_flag,
	output logic             ext_mode,
	output logic             ddr_enable,
	output logic             out_edge_rising,
	output logic             ddr_phase_90,
	output logic             cal_delay_long,
	output logic             fsr_high,
	output logic             core_power_down,
	output logic             conv_rise_en,
	output logic             conv_fall_en,
	output logic             buffer_write_en,
	output logic [8:0]       full_scale_code,
	output logic [8:0]       offset_code,
	output logic [15:0]      phase_fine,
	output logic [15:0]      phase_coarse,
	output logic             pattern_enable,
	output logic             diff_reset_en,
	output logic             duty_stab_en,
	output logic             trim_disable,
	output logic [15:0]      buffer_setup
);

	// Take the 9-bit adjust field out of a trim register
	function automatic logic [8:0] adj_field(input logic [15:0] r);
		adj_field = r[CMCS_ADJ_MSB:CMCS_ADJ_LSB];
	endfunction

	logic [5:0]    pin_q1_r;
	logic [5:0]    pin_q2_r;
	logic [1:0]    mode_s;
	logic [1:0]    rate_s;
	logic          cal_s;
	logic          pd_s;
	cmcs_mode_st_t mode_st_r;
	logic [1:0]    settle_cnt_r;
	logic          frame_valid;
	logic [3:0]    frame_addr;
	logic [15:0]   frame_data;
	logic [15:0]   cfg_r;
	logic [15:0]   offset_r;
	logic [15:0]   fullscl_r;
	logic [15:0]   ph_fine_r;
	logic [15:0]   ph_crs_r;
	logic [15:0]   buf_pat_r;
	logic          reg_wr;
	logic          take;
	logic          slow_word;
	logic          half_r;
	logic [7:0]    pat_r;

	// Pins come from outside: two stages before any logic reads them
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_q1_r <= 6'h0;
			pin_q2_r <= 6'h0;
		end else begin
			pin_q1_r <= {range_or_mode_pin, edge_or_rate_pin,
				cal_delay_pin, power_down_pin};
			pin_q2_r <= pin_q1_r;
		end
	end

	assign mode_s = pin_q2_r[5:4];
	assign rate_s = pin_q2_r[3:2];
	assign cal_s  = pin_q2_r[1];
	assign pd_s   = pin_q2_r[0];

	// Mode is captured once; later pin movement cannot swap sources
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_st_r    <= CMCS_MODE_WAIT;
			settle_cnt_r <= 2'h0;
			ext_mode     <= 1'h0;
		end else begin
			unique case (mode_st_r)
				CMCS_MODE_WAIT: begin
					settle_cnt_r <= settle_cnt_r + 2'h1;
					if (settle_cnt_r == 2'(CMCS_MODE_SETTLE_CYC - 1)) begin
						ext_mode  <= (mode_s == CMCS_PIN_MID);
						mode_st_r <= CMCS_MODE_HELD;
					end
				end
				CMCS_MODE_HELD: begin
					ext_mode <= ext_mode;
				end
			endcase
		end
	end

	cmcs_serial_rx u_serial_rx (
		.clock        (clock),
		.rst          (rst),
		.serial_clk   (serial_clk),
		.serial_data  (serial_data),
		.serial_sel_n (serial_sel_n),
		.frame_valid  (frame_valid),
		.frame_addr   (frame_addr),
		.frame_data   (frame_data)
	);

	// The serial port only works in extended mode
	assign reg_wr = frame_valid & ext_mode;

	// Write-only registers; contents kept through power-down
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_r     <= CMCS_CONFIG_RST;
			offset_r  <= CMCS_OFFSET_RST;
			fullscl_r <= CMCS_FULLSCL_RST;
			ph_fine_r <= CMCS_PH_FINE_RST;
			ph_crs_r  <= CMCS_PH_CRS_RST;
			buf_pat_r <= CMCS_BUF_PAT_RST;
		end else if (reg_wr) begin
			unique case (frame_addr)
				CMCS_ADDR_CONFIG:  cfg_r     <= frame_data;
				CMCS_ADDR_OFFSET:  offset_r  <= frame_data;
				CMCS_ADDR_FULLSCL: fullscl_r <= frame_data;
				CMCS_ADDR_PH_FINE: ph_fine_r <= frame_data;
				CMCS_ADDR_PH_CRS:  ph_crs_r  <= frame_data;
				CMCS_ADDR_BUF_PAT: buf_pat_r <= frame_data;
				default: ; // Reserved addresses are dropped
			endcase
		end
	end

	// Output format: pins in normal mode, registers in extended mode
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ddr_enable      <= 1'h0;
			out_edge_rising <= 1'h0;
			ddr_phase_90    <= 1'h0;
		end else if (ext_mode) begin
			ddr_enable      <= ~cfg_r[CMCS_CFG_SINGLE_BIT];
			out_edge_rising <= cfg_r[CMCS_CFG_EDGE_BIT];
			ddr_phase_90    <= cfg_r[CMCS_CFG_DDR_PH_BIT];
		end else begin
			ddr_enable      <= (rate_s == CMCS_PIN_MID);
			out_edge_rising <= (rate_s == CMCS_PIN_HIGH);
			ddr_phase_90    <= 1'h0;
		end
	end

	// Calibration delay and range pin; extended mode forces the short delay
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cal_delay_long <= 1'h0;
			fsr_high       <= 1'h0;
		end else begin
			cal_delay_long <= ~ext_mode & cal_s;
			fsr_high       <= ~ext_mode &
				(mode_s == CMCS_PIN_HIGH);
		end
	end

	// Trims and options; normal mode shows fixed values so regs do nothing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			full_scale_code <= adj_field(CMCS_FULLSCL_RST);
			offset_code     <= adj_field(CMCS_OFFSET_RST);
			phase_fine      <= CMCS_PH_FINE_RST;
			phase_coarse    <= CMCS_PH_CRS_RST;
			pattern_enable  <= 1'h0;
			diff_reset_en   <= 1'h0;
			duty_stab_en    <= 1'h1;
			trim_disable    <= 1'h0;
			buffer_setup    <= CMCS_BUF_PAT_RST;
		end else if (ext_mode) begin
			full_scale_code <= adj_field(fullscl_r);
			offset_code     <= adj_field(offset_r);
			phase_fine      <= ph_fine_r;
			phase_coarse    <= ph_crs_r;
			pattern_enable  <= buf_pat_r[CMCS_PAT_SEL_BIT];
			diff_reset_en   <= cfg_r[CMCS_CFG_DIFF_RST_BIT];
			duty_stab_en    <= cfg_r[CMCS_CFG_DUTY_STAB_BIT];
			trim_disable    <= cfg_r[CMCS_CFG_TRIM_DIS_BIT];
			buffer_setup    <= buf_pat_r;
		end else begin
			full_scale_code <= adj_field(CMCS_FULLSCL_RST);
			offset_code     <= adj_field(CMCS_OFFSET_RST);
			phase_fine      <= CMCS_PH_FINE_RST;
			phase_coarse    <= CMCS_PH_CRS_RST;
			pattern_enable  <= 1'h0;
			diff_reset_en   <= 1'h0;
			duty_stab_en    <= 1'h1;
			trim_disable    <= 1'h0;
			buffer_setup    <= CMCS_BUF_PAT_RST;
		end
	end

	// Power-down stops the core, both converters and buffer writes only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			core_power_down <= 1'h0;
			conv_rise_en    <= 1'h0;
			conv_fall_en    <= 1'h0;
			buffer_write_en <= 1'h0;
		end else begin
			core_power_down <= pd_s;
			conv_rise_en    <= ~pd_s;
			conv_fall_en    <= ~pd_s;
			buffer_write_en <= ~pd_s;
		end
	end

	// Buffer flags are re-timed but never gated by power-down
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			buffer_empty_flag <= 1'h1;
			capture_full_flag <= 1'h0;
			out_of_range_flag <= 1'h0;
		end else begin
			buffer_empty_flag <= buffer_empty_in;
			capture_full_flag <= capture_full_in;
			out_of_range_flag <= out_of_range_in;
		end
	end

	// Words need two clocks unless double rate at zero phase
	assign slow_word = ~(ddr_enable & ~ddr_phase_90);
	assign take      = buf_word_valid & buf_word_ready;

	// Word pacing; ready drops for the second half of a slow word
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			buf_word_ready <= 1'h0;
			half_r         <= 1'h0;
		end else begin
			buf_word_ready <= ~(take & slow_word);
			half_r         <= take & slow_word;
		end
	end

	// Data launch; pattern replaces buffer data, second bus inverted
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			data_a <= 8'h0;
			data_b <= 8'h0;
			pat_r  <= 8'h0;
		end else if (take) begin
			pat_r  <= pat_r + 8'h1;
			data_a <= pattern_enable ? pat_r : buf_word_a;
			data_b <= pattern_enable ? ~pat_r : buf_word_b;
		end
	end

	// Strobe: single rate gives one full period per word on chosen edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			output_strobe <= 1'h0;
		end else if (take && !ddr_enable) begin
			output_strobe <= out_edge_rising;
		end else if (take && !ddr_phase_90) begin
			output_strobe <= ~output_strobe;
		end else if (half_r) begin
			output_strobe <= ~output_strobe;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_MODE_LOCK: assert property (
		mode_st_r == CMCS_MODE_HELD |=> $stable(ext_mode))
		else $error("control mode changed after capture");

	AST_NORM_DDR: assert property (
		mode_st_r == CMCS_MODE_HELD && !ext_mode &&
		rate_s == CMCS_PIN_MID |=> ddr_enable)
		else $error("mid rate pin did not select double rate");

	AST_EXT_DDR: assert property (
		ext_mode && !cfg_r[CMCS_CFG_SINGLE_BIT] |=> ddr_enable)
		else $error("cleared single rate bit did not give double rate");

	AST_NORM_PHASE: assert property (
		!ext_mode |=> !ddr_phase_90)
		else $error("strobe phase not zero in normal mode");

	AST_CAL_SHORT: assert property (
		ext_mode |=> !cal_delay_long)
		else $error("long calibration delay in extended mode");

	AST_POWER_DOWN: assert property (
		pd_s |=> core_power_down && !buffer_write_en && !conv_rise_en)
		else $error("power-down did not stop core and writes");

	AST_NORM_NOREG: assert property (
		!ext_mode |=> !pattern_enable &&
		offset_code == adj_field(CMCS_OFFSET_RST))
		else $error("register value acted in normal mode");

	AST_SDR_STROBE: assert property (
		take && !ddr_enable |=> output_strobe == $past(out_edge_rising)
		##1 output_strobe != $past(out_edge_rising, 2))
		else $error("single rate strobe period wrong");

	AST_DDR_STROBE: assert property (
		take && ddr_enable && !ddr_phase_90 |=>
		output_strobe != $past(output_strobe))
		else $error("double rate strobe did not toggle with word");

	AST_DDR_PH90: assert property (
		take && ddr_enable && ddr_phase_90 |=>
		$stable(output_strobe) ##1 $changed(output_strobe))
		else $error("shifted strobe did not toggle mid word");

	AST_CFG_WRITE: assert property (
		reg_wr && frame_addr == CMCS_ADDR_CONFIG |=>
		cfg_r == $past(frame_data))
		else $error("configuration write lost");

endmodule // cmcs_top
`default_nettype wire

// >>> verif/cmcs_host_model.sv
// Host model: drives the mode pin and writes registers over the serial link
`timescale 1ns/100ps
`default_nettype none
module cmcs_host_model
	import cmcs_pkg::*;
(
	output logic [1:0] range_or_mode_pin,
	output logic       serial_clk,
	output logic       serial_data,
	output logic       serial_sel_n
);
	// Serial clock half period; raise it to act as a slow host
	int half_ns = 200;

	// Idle link: clock parked low, device not selected
	initial begin
		range_or_mode_pin = CMCS_PIN_HIGH;
		serial_clk = 1'b0;
		serial_data = 1'b1;
		serial_sel_n = 1'b1;
	end

	// Mode pin is changed at once; the device need not be in reset
	task automatic set_mode(input logic [1:0] code);
		range_or_mode_pin = code;
	endtask

	// One frame, header then address then data, all MSB first
	task automatic write_reg(input logic [11:0] hdr, input logic [3:0] adr,
		input logic [15:0] dat);
		logic [31:0] frame;
		frame = {hdr, adr, dat};
		serial_sel_n = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			serial_data = frame[i];
			#(half_ns) serial_clk = 1'b1;
			#(half_ns) serial_clk = 1'b0;
		end
		#(half_ns) serial_sel_n = 1'b1;
		// Released line must not keep showing the last bit
		serial_data = ~serial_data;
		// Stay deselected a while so a following frame starts cleanly
		#(half_ns);
	endtask
endmodule // cmcs_host_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking testbench for the control mode configuration select block
`timescale 1ns/100ps
`default_nettype none
module testbench
	import cmcs_pkg::*;
;
	localparam logic [1:0] PINS [3] = '{CMCS_PIN_LOW, CMCS_PIN_HIGH,
		CMCS_PIN_MID};
	localparam logic [3:0] ADRS [4] = '{CMCS_ADDR_OFFSET, CMCS_ADDR_FULLSCL,
		CMCS_ADDR_PH_FINE, CMCS_ADDR_PH_CRS};
	logic        clock, rst, cal_delay_pin, power_down_pin;
	logic        serial_clk, serial_data, serial_sel_n, buf_word_valid;
	logic        buffer_empty_in, capture_full_in, out_of_range_in;
	logic [1:0]  range_or_mode_pin, edge_or_rate_pin;
	logic [7:0]  buf_word_a, buf_word_b, data_a, data_b;
	logic        buf_word_ready, output_strobe, buffer_empty_flag;
	logic        capture_full_flag, out_of_range_flag, ext_mode, ddr_enable;
	logic        out_edge_rising, ddr_phase_90, cal_delay_long, fsr_high;
	logic        core_power_down, conv_rise_en, conv_fall_en;
	logic        buffer_write_en, pattern_enable, diff_reset_en;
	logic        duty_stab_en, trim_disable;
	logic [8:0]  full_scale_code, offset_code, fs;
	logic [15:0] phase_fine, phase_coarse, buffer_setup, d;
	logic [16:0] exp_q [$];
	logic [16:0] nt;
	logic        pend, chk2, s0;
	int          miscompares = 0;
	int          total_checks = 0;

	cmcs_host_model i_host (.range_or_mode_pin(range_or_mode_pin),
		.serial_clk(serial_clk), .serial_data(serial_data),
		.serial_sel_n(serial_sel_n));

	cmcs_top i_cmcs_top (.clock(clock), .rst(rst),
		.range_or_mode_pin(range_or_mode_pin),
		.edge_or_rate_pin(edge_or_rate_pin), .cal_delay_pin(cal_delay_pin),
		.power_down_pin(power_down_pin), .serial_clk(serial_clk),
		.serial_data(serial_data), .serial_sel_n(serial_sel_n),
		.buf_word_a(buf_word_a), .buf_word_b(buf_word_b),
		.buf_word_valid(buf_word_valid), .buffer_empty_in(buffer_empty_in),
		.capture_full_in(capture_full_in), .out_of_range_in(out_of_range_in),
		.buf_word_ready(buf_word_ready), .data_a(data_a), .data_b(data_b),
		.output_strobe(output_strobe), .buffer_empty_flag(buffer_empty_flag),
		.capture_full_flag(capture_full_flag),
		.out_of_range_flag(out_of_range_flag), .ext_mode(ext_mode),
		.ddr_enable(ddr_enable), .out_edge_rising(out_edge_rising),
		.ddr_phase_90(ddr_phase_90), .cal_delay_long(cal_delay_long),
		.fsr_high(fsr_high), .core_power_down(core_power_down),
		.conv_rise_en(conv_rise_en), .conv_fall_en(conv_fall_en),
		.buffer_write_en(buffer_write_en), .full_scale_code(full_scale_code),
		.offset_code(offset_code), .phase_fine(phase_fine),
		.phase_coarse(phase_coarse), .pattern_enable(pattern_enable),
		.diff_reset_en(diff_reset_en), .duty_stab_en(duty_stab_en),
		.trim_disable(trim_disable), .buffer_setup(buffer_setup));

	// 20 MHz block clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Offer one word and note it once the design will take it
	task automatic send(input logic [7:0] a, input logic [7:0] b,
		input logic pat);
		int n;
		@(negedge clock);
		buf_word_a = a;
		buf_word_b = b;
		buf_word_valid = 1'b1;
		n = 0;
		while (buf_word_ready !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > 20) begin
				miscompares++;
				final_report;
			end
		end
		exp_q.push_back({pat, a, b});
		@(posedge clock);
	endtask

	// Back-to-back words; valid stays up between them
	task automatic burst(input int cnt, input logic pat);
		for (int i = 0; i < cnt; i++)
			send(8'($urandom), 8'($urandom), pat);
		@(negedge clock);
		buf_word_valid = 1'b0;
		repeat (4) @(negedge clock);
	endtask

	task automatic wr_cfg(input logic [15:0] v);
		i_host.write_reg(CMCS_FRAME_HDR, CMCS_ADDR_CONFIG, v);
		repeat (4) @(negedge clock);
		check(ddr_enable, !v[CMCS_CFG_SINGLE_BIT]);
		check(out_edge_rising, v[CMCS_CFG_EDGE_BIT]);
		check(ddr_phase_90, v[CMCS_CFG_DDR_PH_BIT]);
	endtask

	task automatic do_reset(input logic [1:0] mode);
		rst = 1'b1;
		i_host.set_mode(mode);
		repeat (4) @(negedge clock);
		rst = 1'b0;
		repeat (8) @(negedge clock);
	endtask

	// Watcher: sampled well after the falling edge so drivers have settled
	initial begin
		pend = 1'b0;
		chk2 = 1'b0;
		s0 = 1'b0;
	end
	always @(negedge clock) begin
		#5;
		if (chk2) begin
			chk2 = 1'b0;
			if (!ddr_enable)
				check(output_strobe, !out_edge_rising);
			else
				check(output_strobe, !s0);
		end
		if (pend) begin
			nt = exp_q.pop_front();
			if (nt[16])
				check(data_a ^ data_b, 8'hff);
			else
				check({data_a, data_b}, nt[15:0]);
			if (!ddr_enable)
				check(output_strobe, out_edge_rising);
			else
				check(output_strobe, ddr_phase_90 ? s0 : !s0);
			chk2 = !(ddr_enable && !ddr_phase_90);
		end
		s0 = output_strobe;
		pend = buf_word_valid && buf_word_ready;
	end

	// Hang guard
	initial begin
		#2000000;
		miscompares++;
		final_report;
	end

	initial begin
		rst = 1'b1;
		edge_or_rate_pin = CMCS_PIN_LOW;
		cal_delay_pin = 1'b0;
		power_down_pin = 1'b0;
		buf_word_a = 8'h00;
		buf_word_b = 8'h00;
		buf_word_valid = 1'b0;
		buffer_empty_in = 1'b1;
		capture_full_in = 1'b0;
		out_of_range_in = 1'b0;
		void'($urandom(69567));
		repeat (4) @(negedge clock);
		rst = 1'b0;
		repeat (8) @(negedge clock);
		// Pin-controlled mode: each rate pin level, words in every case
		check(ext_mode, 1'b0);
		for (int i = 0; i < 3; i++) begin
			edge_or_rate_pin = PINS[i];
			cal_delay_pin = 1'(i);
			repeat (4) @(negedge clock);
			check(ddr_enable, PINS[i] == CMCS_PIN_MID);
			check(out_edge_rising, PINS[i] == CMCS_PIN_HIGH);
			check(ddr_phase_90, 1'b0);
			check(cal_delay_long, cal_delay_pin);
			check({conv_rise_en, conv_fall_en}, 2'h3);
			burst(3, 1'b0);
		end
		i_host.write_reg(CMCS_FRAME_HDR, CMCS_ADDR_FULLSCL, 16'h0000);
		i_host.write_reg(CMCS_FRAME_HDR, CMCS_ADDR_PH_FINE, 16'h1234);
		repeat (4) @(negedge clock);
		check(full_scale_code, 9'h100);
		check(phase_fine, 16'h0000);
		check(fsr_high, 1'b1);
		check({trim_disable, buffer_setup}, {1'b0, CMCS_BUF_PAT_RST});
		// Power-down keeps the readout side alive
		power_down_pin = 1'b1;
		buffer_empty_in = 1'b0;
		capture_full_in = 1'b1;
		out_of_range_in = 1'b1;
		repeat (4) @(negedge clock);
		check(core_power_down, 1'b1);
		check(buffer_write_en, 1'b0);
		check(buffer_empty_flag, 1'b0);
		check({capture_full_flag, out_of_range_flag}, 2'h3);
		check({conv_rise_en, conv_fall_en}, 2'h0);
		burst(2, 1'b0);
		power_down_pin = 1'b0;
		repeat (4) @(negedge clock);
		check(core_power_down, 1'b0);
		// Deliberate mode pin change after capture
		i_host.set_mode(CMCS_PIN_MID);
		repeat (6) @(negedge clock);
		check(ext_mode, 1'b0);
		$display("Test normal control done");
		// Register-controlled mode; pins set to non-default levels first
		edge_or_rate_pin = CMCS_PIN_MID;
		cal_delay_pin = 1'b1;
		do_reset(CMCS_PIN_MID);
		check(ext_mode, 1'b1);
		check({ddr_enable, out_edge_rising, ddr_phase_90}, 3'h1);
		check({cal_delay_long, fsr_high}, 2'h0);
		check({pattern_enable, diff_reset_en, duty_stab_en}, 3'h1);
		check(trim_disable, 1'b0);
		check({full_scale_code, offset_code}, {9'h100, 9'h000});
		check({phase_fine, phase_coarse}, 32'h0);
		burst(2, 1'b0);
		i_host.half_ns = 500;
		wr_cfg(CMCS_CONFIG_RST | 16'h0100);
		i_host.half_ns = 200;
		burst(2, 1'b0);
		wr_cfg(CMCS_CONFIG_RST & 16'hf2ff);
		burst(3, 1'b0);
		wr_cfg(CMCS_CONFIG_RST & 16'hfaff);
		burst(2, 1'b0);
		for (int i = 0; i < 4; i++) begin
			d = 16'($urandom);
			i_host.write_reg(CMCS_FRAME_HDR, ADRS[i], d);
			repeat (4) @(negedge clock);
			case (i)
				0: check(offset_code, d[15:7]);
				1: check(full_scale_code, d[15:7]);
				2: check(phase_fine, d);
				default: check(phase_coarse, d);
			endcase
			if (i == 1)
				fs = d[15:7];
		end
		// Reserved address and bad header leave the trims alone
		i_host.write_reg(CMCS_FRAME_HDR, 4'h4, 16'h0000);
		i_host.write_reg(12'h003, CMCS_ADDR_FULLSCL, 16'h0000);
		repeat (4) @(negedge clock);
		check(full_scale_code, fs);
		i_host.write_reg(CMCS_FRAME_HDR, CMCS_ADDR_BUF_PAT, 16'h0800);
		repeat (4) @(negedge clock);
		check(pattern_enable, 1'b1);
		check(buffer_setup, 16'h0800);
		burst(3, 1'b1);
		$display("Test extended control done");
		final_report;
	end
endmodule // testbench
`default_nettype wire
